// [design/usb_endpoint_mode_map.vh]
`ifndef USB_ENDPOINT_MODE_MAP_VH
`define USB_ENDPOINT_MODE_MAP_VH

// ----------------------------------------
// Endpoint mode encodings
// ----------------------------------------
`define MODE_DISABLE 4'h0
`define MODE_NAK_IN_OUT 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_IN_OUT 4'h3
`define MODE_STATUS_IN 4'h6
`define MODE_ACK_OUT_STATUS_IN 4'hB
`define MODE_ACK_IN_STATUS_OUT 4'hF
`define MODE_NAK_OUT 4'h8
`define MODE_ACK_OUT 4'h9
`define MODE_NAK_IN 4'hC
`define MODE_ACK_IN 4'hD

// ----------------------------------------
// Token and response codes
// ----------------------------------------
`define PID_SETUP 2'h0
`define PID_IN 2'h1
`define PID_OUT 2'h2
`define RESP_ACK 3'h1
`define RESP_NAK 3'h2
`define RESP_STALL 3'h3
`define RESP_DATA 3'h4

// ----------------------------------------
// Packet limits and sizes
// ----------------------------------------
`define PKT_MAX_LEN 5'hA
`define PKT_STATUS_LEN 5'h2
`define NUM_EP 3
`define FIFO_WIDTH 8
`define FIFO_DEPTH 32
`define FIFO_AW 5

`endif

// [design/byte_fifo.v]
`timescale 1ns/100ps
`include "usb_endpoint_mode_map.vh"

module byte_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clk, // System clock
  input wire sys_rst, // Async reset, active high
  input wire [WIDTH-1:0] in_data, // Write data
  input wire in_valid, // Write request
  output reg in_ready_r, // Room for a word
  output reg [WIDTH-1:0] out_data_r, // Read data
  output reg out_valid_r, // Read data present
  input wire out_ready // Reader takes word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  reg [AW:0] count_nxt;
  wire push;
  wire pop;

  assign push = in_valid && in_ready_r;
  // Refill the output stage when empty or being taken
  assign pop = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready);

  always @* begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready_r <= 1'b0;
      out_data_r <= {WIDTH{1'b0}};
      out_valid_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      // Output stage holds a word too, so the store keeps one back
      in_ready_r <= (count_nxt < DEPTH - 1);
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        out_data_r <= mem[rd_ptr_r];
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end

endmodule

// [design/usb_endpoint_mode_responder.v]
// Operation
// - Mode 0000: no answer at all to SETUP, IN or OUT.
// - Control 0001: accept SETUP, NAK every IN and every good OUT.
// - Control 0010: accept SETUP, STALL IN, status check on OUT.
// - Control 0011: accept SETUP, STALL every IN and every good OUT.
// - Control 0110: accept SETUP, zero-byte data on IN, STALL OUT.
// - Control 1011: accept SETUP, ACK OUT, zero-byte data on IN.
// - Control 1111: accept SETUP, counted data on IN, status check OUT.
// - Data 1000: ignore SETUP and IN, NAK OUT.
// - Data 1001 unstalled: ACK OUT, then engine sets mode 1000.
// - Data 1001 stalled: STALL OUT, ignore SETUP and IN.
// - Data 1100: ignore SETUP and OUT, NAK IN.
// - Data 1101 unstalled: send counted IN data, host ACK sets 1100.
// - Data 1101 stalled: STALL IN, ignore SETUP and OUT.
// - Reserved encodings ignore all tokens; firmware must avoid them.
// - Status check ACKs only zero data bytes with toggle 1.
// - Counted IN sends exactly the endpoint's four-bit byte count.
// - Four-bit mode field per endpoint selects its behaviour.
// - Valid SETUP: ACK, mode 0001, store, toggle, count, valid, interrupt.
// - Engine mode write beats a same-cycle firmware mode write.
`timescale 1ns/100ps
`include "usb_endpoint_mode_map.vh"

module usb_endpoint_mode_responder (
  input wire clk, // System clock
  input wire sys_rst, // Async reset, active high
  input wire tok_valid, // Token with its data phase done
  input wire [1:0] tok_pid, // SETUP, IN or OUT
  input wire [1:0] tok_ep, // Addressed endpoint
  input wire [4:0] pkt_len, // Data packet bytes incl CRC
  input wire pkt_ok, // Data packet passed checks
  input wire pkt_tog, // Data packet toggle
  input wire host_ack, // Host ACKed our IN data
  input wire host_noack, // Host gave no ACK to IN data
  input wire fw_we, // Firmware mode write
  input wire [1:0] fw_ep, // Endpoint of firmware write
  input wire [3:0] fw_mode, // Mode value written
  input wire [2:0] fw_stall, // Stall bit per endpoint
  input wire [11:0] fw_count, // Byte count per endpoint
  input wire [7:0] rx_data, // Received packet byte
  input wire rx_valid, // Received byte present
  output wire rx_ready, // Room for received byte
  output wire [7:0] buf_data, // Byte toward endpoint buffer
  output wire buf_valid, // Buffer byte present
  input wire buf_ready, // Buffer takes byte
  output reg resp_valid_r, // Response strobe
  output reg [2:0] resp_code_r, // ACK, NAK, STALL or DATA
  output reg [1:0] resp_ep_r, // Endpoint answered
  output reg [3:0] resp_len_r, // Data bytes to send
  output reg resp_tog_r, // Toggle of data sent
  output wire [11:0] ep_mode, // Mode field per endpoint
  output wire [2:0] ep_dtog, // Received toggle per endpoint
  output wire [2:0] ep_dval, // Data valid per endpoint
  output wire [14:0] ep_rxcnt, // Received count per endpoint
  output wire [2:0] ep_int // Endpoint interrupt pulses
);

  // ----------------------------------------
  // Handshake state
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] wait_ep_r;
  reg [3:0] wait_tgt_r;

  // ----------------------------------------
  // Token decode
  // ----------------------------------------
  wire [3:0] cur_mode;
  wire cur_stall;
  wire is_ctrl;
  wire ep_ok;
  wire pkt_good;
  wire status_ok;
  wire [3:0] cur_count;
  wire tok_take;

  reg [2:0] r_code;
  reg [3:0] r_len;
  reg e_we;
  reg [3:0] e_mode;
  reg e_int;
  reg d_upd;
  reg go_wait;
  reg [3:0] go_tgt;

  reg [1:0] eng_ep;
  reg eng_we;
  reg [3:0] eng_mode;
  reg eng_int;

  assign ep_ok = (tok_ep < 2'd3);
  assign is_ctrl = (tok_ep == 2'd0);
  assign cur_mode = ep_mode[{tok_ep, 2'b00} +: 4];
  assign cur_stall = fw_stall[tok_ep];
  assign cur_count = fw_count[{tok_ep, 2'b00} +: 4];
  assign pkt_good = pkt_ok && (pkt_len <= `PKT_MAX_LEN);
  assign status_ok = pkt_good && (pkt_len == `PKT_STATUS_LEN) && pkt_tog;
  // A host handshake outranks a token in the same cycle
  assign tok_take = tok_valid && ep_ok && !host_ack;

  always @* begin
    r_code = 3'h0;
    r_len = 4'h0;
    e_we = 1'b0;
    e_mode = cur_mode;
    e_int = 1'b0;
    d_upd = 1'b0;
    go_wait = 1'b0;
    go_tgt = cur_mode;
    if (is_ctrl) begin
      case (cur_mode)
        `MODE_NAK_IN_OUT, `MODE_STATUS_OUT, `MODE_STALL_IN_OUT,
        `MODE_STATUS_IN, `MODE_ACK_OUT_STATUS_IN,
        `MODE_ACK_IN_STATUS_OUT: begin
          if (tok_pid == `PID_SETUP) begin
            if (pkt_good) begin
              r_code = `RESP_ACK;
              e_we = 1'b1;
              e_mode = `MODE_NAK_IN_OUT;
              e_int = 1'b1;
              d_upd = 1'b1;
            end
          end else if (tok_pid == `PID_IN) begin
            case (cur_mode)
              `MODE_NAK_IN_OUT: begin
                r_code = `RESP_NAK;
              end
              `MODE_STATUS_OUT: begin
                r_code = `RESP_STALL;
                e_we = 1'b1;
                e_mode = `MODE_STALL_IN_OUT;
                e_int = 1'b1;
              end
              `MODE_STALL_IN_OUT: begin
                r_code = `RESP_STALL;
              end
              `MODE_STATUS_IN, `MODE_ACK_OUT_STATUS_IN: begin
                r_code = `RESP_DATA;
                go_wait = 1'b1;
                go_tgt = `MODE_STALL_IN_OUT;
              end
              default: begin
                r_code = `RESP_DATA;
                r_len = cur_count;
                go_wait = 1'b1;
                go_tgt = `MODE_NAK_IN_OUT;
              end
            endcase
          end else if (tok_pid == `PID_OUT && pkt_good) begin
            case (cur_mode)
              `MODE_NAK_IN_OUT: begin
                r_code = `RESP_NAK;
              end
              `MODE_STALL_IN_OUT: begin
                r_code = `RESP_STALL;
              end
              `MODE_STATUS_IN: begin
                r_code = `RESP_STALL;
                e_we = 1'b1;
                e_mode = `MODE_STALL_IN_OUT;
                e_int = 1'b1;
              end
              `MODE_ACK_OUT_STATUS_IN: begin
                r_code = `RESP_ACK;
                e_we = 1'b1;
                e_mode = `MODE_NAK_IN_OUT;
                e_int = 1'b1;
                d_upd = 1'b1;
              end
              default: begin
                e_int = 1'b1;
                if (status_ok) begin
                  r_code = `RESP_ACK;
                  d_upd = 1'b1;
                  e_we = (cur_mode == `MODE_ACK_IN_STATUS_OUT);
                  e_mode = `MODE_STATUS_OUT;
                end else begin
                  r_code = `RESP_STALL;
                  e_we = 1'b1;
                  e_mode = `MODE_STALL_IN_OUT;
                end
              end
            endcase
          end
        end
        // Disabled and reserved modes stay silent
        default: begin
          r_code = 3'h0;
        end
      endcase
    end else begin
      case (cur_mode)
        `MODE_NAK_OUT: begin
          if (tok_pid == `PID_OUT && pkt_good) begin
            r_code = `RESP_NAK;
          end
        end
        `MODE_ACK_OUT: begin
          if (tok_pid == `PID_OUT && pkt_good) begin
            if (cur_stall) begin
              r_code = `RESP_STALL;
            end else begin
              r_code = `RESP_ACK;
              e_we = 1'b1;
              e_mode = `MODE_NAK_OUT;
              e_int = 1'b1;
              d_upd = 1'b1;
            end
          end
        end
        `MODE_NAK_IN: begin
          if (tok_pid == `PID_IN) begin
            r_code = `RESP_NAK;
          end
        end
        `MODE_ACK_IN: begin
          if (tok_pid == `PID_IN) begin
            if (cur_stall) begin
              r_code = `RESP_STALL;
            end else begin
              r_code = `RESP_DATA;
              r_len = cur_count;
              go_wait = 1'b1;
              go_tgt = `MODE_NAK_IN;
            end
          end
        end
        // Disabled and reserved modes stay silent
        default: begin
          r_code = 3'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Engine mode write selection
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    eng_ep = tok_ep;
    eng_we = 1'b0;
    eng_mode = e_mode;
    eng_int = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (tok_take) begin
          eng_we = e_we;
          eng_int = e_int;
          if (go_wait) begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (host_ack) begin
          // Host ACK of IN data rewrites the mode
          eng_ep = wait_ep_r;
          eng_we = 1'b1;
          eng_mode = wait_tgt_r;
          eng_int = 1'b1;
          state_nxt = ST_IDLE;
        end else if (tok_take) begin
          // New token abandons the unanswered IN
          eng_we = e_we;
          eng_int = e_int;
          state_nxt = go_wait ? ST_WAIT : ST_IDLE;
        end else if (host_noack) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      wait_ep_r <= 2'h0;
      wait_tgt_r <= 4'h0;
      resp_valid_r <= 1'b0;
      resp_code_r <= 3'h0;
      resp_ep_r <= 2'h0;
      resp_len_r <= 4'h0;
      resp_tog_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      resp_valid_r <= tok_take && (r_code != 3'h0);
      if (tok_take) begin
        resp_code_r <= r_code;
        resp_ep_r <= tok_ep;
        resp_len_r <= r_len;
        resp_tog_r <= fw_count[{tok_ep, 2'b00} + 2'd3] ^ 1'b0;
        if (go_wait) begin
          wait_ep_r <= tok_ep;
          wait_tgt_r <= go_tgt;
        end
      end
    end
  end

  // ----------------------------------------
  // Per-endpoint mode and count state
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EP; gi = gi + 1) begin : g_ep
      reg [3:0] mode_r;
      reg dtog_r;
      reg dval_r;
      reg [4:0] cnt_r;
      reg int_r;
      wire eng_hit;
      wire fw_hit;
      wire upd_hit;

      assign eng_hit = eng_we && (eng_ep == gi);
      // Any engine write blocks the firmware write
      assign fw_hit = fw_we && !eng_we && (fw_ep == gi);
      assign upd_hit = tok_take && d_upd && (tok_ep == gi);

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          mode_r <= `MODE_DISABLE;
          dtog_r <= 1'b0;
          dval_r <= 1'b0;
          cnt_r <= 5'h0;
          int_r <= 1'b0;
        end else begin
          if (eng_hit) begin
            mode_r <= eng_mode;
          end else if (fw_hit) begin
            mode_r <= fw_mode;
          end
          if (upd_hit) begin
            dtog_r <= pkt_tog;
            dval_r <= 1'b1;
            cnt_r <= pkt_len;
          end
          int_r <= eng_int && (eng_ep == gi);
        end
      end

      assign ep_mode[4*gi +: 4] = mode_r;
      assign ep_dtog[gi] = dtog_r;
      assign ep_dval[gi] = dval_r;
      assign ep_rxcnt[5*gi +: 5] = cnt_r;
      assign ep_int[gi] = int_r;
    end
  endgenerate

  // ----------------------------------------
  // Received bytes toward endpoint buffers
  // ----------------------------------------
  // Bytes of rejected packets pass too; the buffer may hold junk
  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_rx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready_r(rx_ready),
    .out_data_r(buf_data),
    .out_valid_r(buf_valid),
    .out_ready(buf_ready)
  );

endmodule

// [verif/usb_endpoint_mode_props.sv]
`timescale 1ns/100ps
`include "usb_endpoint_mode_map.vh"

module usb_endpoint_mode_props (
  input wire clk, // System clock
  input wire sys_rst, // Async reset, active high
  input wire tok_valid, // Token strobe
  input wire [1:0] tok_pid, // Token kind
  input wire [1:0] tok_ep, // Token endpoint
  input wire [4:0] pkt_len, // Packet bytes
  input wire pkt_ok, // Packet checks passed
  input wire host_ack, // Host ACK pulse
  input wire [2:0] fw_stall, // Stall bits
  input wire [11:0] fw_count, // Byte counts
  input wire resp_valid_r, // Response strobe
  input wire [2:0] resp_code_r, // Response code
  input wire [3:0] resp_len_r, // Data length
  input wire [11:0] ep_mode, // Modes
  input wire [2:0] ep_int, // Interrupt pulses
  input wire [2:0] ep_dval // Data valid
);
  reg [1:0] last_ep_r;
  wire take = tok_valid && !host_ack && tok_ep != 2'h3;
  wire [3:0] tm = ep_mode[tok_ep*4 +: 4];
  wire [3:0] tc = fw_count[tok_ep*4 +: 4];
  wire st = fw_stall[tok_ep];
  wire ctl = tok_ep == 2'h0;
  wire good = pkt_ok && pkt_len <= `PKT_MAX_LEN;
  wire su = tok_pid == `PID_SETUP;
  wire pin = tok_pid == `PID_IN;
  wire pout = tok_pid == `PID_OUT;
  wire [3:0] lm = ep_mode[last_ep_r*4 +: 4];
  wire li = ep_int[last_ep_r];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) last_ep_r <= 2'h0;
    else last_ep_r <= tok_ep;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_disabled_silent;
    take && tm == `MODE_DISABLE |=> !resp_valid_r;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent)
    else $error("disabled endpoint answered");
  property p_nak_ctl;
    take && ctl && tm == `MODE_NAK_IN_OUT && (pin || pout && good)
      |=> resp_valid_r && resp_code_r == `RESP_NAK;
  endproperty
  a_nak_ctl: assert property (p_nak_ctl)
    else $error("control NAK mode did not NAK");
  property p_stall_ctl;
    take && ctl && tm == `MODE_STALL_IN_OUT && (pin || pout && good)
      |-> ##1 resp_valid_r && resp_code_r == `RESP_STALL && lm == 4'h3;
  endproperty
  a_stall_ctl: assert property (p_stall_ctl)
    else $error("control stall mode did not stall");
  property p_setup_ack;
    take && ctl && su && good && tm inside {4'h1, 4'h2, 4'h3, 4'h6, 4'hB,
      4'hF} |=> resp_code_r == `RESP_ACK && ep_mode[3:0] == 4'h1
      && ep_int[0] && ep_dval[0] && resp_valid_r;
  endproperty
  a_setup_ack: assert property (p_setup_ack)
    else $error("setup not acknowledged");
  property p_out_ack_rewrite;
    take && !ctl && pout && good && tm == `MODE_ACK_OUT && !st
      |=> resp_valid_r && resp_code_r == `RESP_ACK && lm == 4'h8 && li;
  endproperty
  a_out_ack_rewrite: assert property (p_out_ack_rewrite)
    else $error("data OUT ack did not rewrite mode");
  property p_out_stalled;
    take && !ctl && pout && good && tm == `MODE_ACK_OUT && st
      |=> resp_valid_r && resp_code_r == `RESP_STALL && $stable(ep_mode);
  endproperty
  a_out_stalled: assert property (p_out_stalled)
    else $error("stalled OUT not stalled");
  property p_nak_in_data;
    take && !ctl && pin && tm == `MODE_NAK_IN
      |=> resp_valid_r && resp_code_r == `RESP_NAK;
  endproperty
  a_nak_in_data: assert property (p_nak_in_data)
    else $error("data IN not NAKed");
  property p_counted;
    take && !ctl && pin && tm == `MODE_ACK_IN && !st
      |=> resp_valid_r && resp_code_r == `RESP_DATA
      && resp_len_r == $past(tc);
  endproperty
  a_counted: assert property (p_counted)
    else $error("counted IN length wrong");
  property p_in_stalled;
    take && !ctl && pin && tm == `MODE_ACK_IN && st
      |=> resp_valid_r && resp_code_r == `RESP_STALL;
  endproperty
  a_in_stalled: assert property (p_in_stalled)
    else $error("stalled IN not stalled");
  property p_reserved;
    take && tm inside {4'h5, 4'h7, 4'hA, 4'h4, 4'hE} |=> !resp_valid_r;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode answered");
  property p_bad_pkt;
    take && !pin && !good |=> !resp_valid_r;
  endproperty
  a_bad_pkt: assert property (p_bad_pkt)
    else $error("bad packet answered");

  c_setup: cover property (take && su && good && ctl);
  c_data: cover property (resp_valid_r && resp_code_r == `RESP_DATA);
  c_host_ack: cover property (host_ack ##1 ep_int != 3'h0);
endmodule

bind usb_endpoint_mode_responder usb_endpoint_mode_props u_props (
  .clk(clk), .sys_rst(sys_rst), .tok_valid(tok_valid),
  .tok_pid(tok_pid), .tok_ep(tok_ep), .pkt_len(pkt_len),
  .pkt_ok(pkt_ok), .host_ack(host_ack), .fw_stall(fw_stall),
  .fw_count(fw_count), .resp_valid_r(resp_valid_r),
  .resp_code_r(resp_code_r), .resp_len_r(resp_len_r),
  .ep_mode(ep_mode), .ep_int(ep_int), .ep_dval(ep_dval)
);

// [verif/usb_host_model.sv]
`timescale 1ns/100ps

module usb_host_model (
  input wire clk, // System clock
  output logic tok_valid, // Token strobe
  output logic [1:0] tok_pid, // Token kind
  output logic [1:0] tok_ep, // Token endpoint
  output logic [4:0] pkt_len, // Packet bytes
  output logic pkt_ok, // Packet checks passed
  output logic pkt_tog, // Packet toggle
  output logic host_ack, // ACK of IN data
  output logic host_noack // No ACK of IN data
);
  initial begin
    tok_valid = 1'b0;
    tok_pid = 2'h3;
    tok_ep = 2'h3;
    pkt_len = 5'h1F;
    pkt_ok = 1'b0;
    pkt_tog = 1'b0;
    host_ack = 1'b0;
    host_noack = 1'b0;
  end

  // Qualifiers flip once released, so stale values never pass
  task token(input [1:0] pid, input [1:0] ep, input [4:0] len,
             input ok, input tog);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    tok_ep <= ep;
    pkt_len <= len;
    pkt_ok <= ok;
    pkt_tog <= tog;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_pid <= ~pid;
    tok_ep <= ~ep;
    pkt_len <= ~len;
    pkt_ok <= ~ok;
    pkt_tog <= ~tog;
  endtask

  task give_ack(input a);
    @(posedge clk);
    host_ack <= a;
    host_noack <= !a;
    @(posedge clk);
    host_ack <= 1'b0;
    host_noack <= 1'b0;
  endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
`include "usb_endpoint_mode_map.vh"

module tb_top;
  localparam [1:0] SU = `PID_SETUP;
  localparam [1:0] IN = `PID_IN;
  localparam [1:0] OU = `PID_OUT;
  localparam [2:0] AK = `RESP_ACK;
  localparam [2:0] NK = `RESP_NAK;
  localparam [2:0] SL = `RESP_STALL;
  localparam [2:0] DT = `RESP_DATA;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fw_we = 1'b0;
  logic [1:0] fw_ep = 2'h0;
  logic [3:0] fw_mode = 4'h0;
  logic [2:0] fw_stall = 3'h0;
  logic [11:0] fw_count = 12'h000;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic buf_ready = 1'b0;
  logic rdy;
  logic [3:0] rsv [5] = '{4'h5, 4'h7, 4'hA, 4'h4, 4'hE};
  wire tok_valid, pkt_ok, pkt_tog, host_ack, host_noack;
  wire [1:0] tok_pid, tok_ep, resp_ep_r;
  wire [4:0] pkt_len;
  wire rx_ready, buf_valid, resp_valid_r, resp_tog_r;
  wire [7:0] buf_data;
  wire [2:0] resp_code_r, ep_dtog, ep_dval, ep_int;
  wire [3:0] resp_len_r;
  wire [11:0] ep_mode;
  wire [14:0] ep_rxcnt;
  wire [15:0] mode_all = {4'h0, ep_mode};
  wire [3:0] int_all = {1'b0, ep_int};
  int fails = 0;
  int samples_checked = 0;
  int n, k;

  always #20 clk = ~clk;

  usb_host_model u_host (.clk(clk), .tok_valid(tok_valid),
    .tok_pid(tok_pid), .tok_ep(tok_ep), .pkt_len(pkt_len),
    .pkt_ok(pkt_ok), .pkt_tog(pkt_tog), .host_ack(host_ack),
    .host_noack(host_noack));

  usb_endpoint_mode_responder u_dut (.clk(clk), .sys_rst(sys_rst),
    .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep),
    .pkt_len(pkt_len), .pkt_ok(pkt_ok), .pkt_tog(pkt_tog),
    .host_ack(host_ack), .host_noack(host_noack), .fw_we(fw_we),
    .fw_ep(fw_ep), .fw_mode(fw_mode), .fw_stall(fw_stall),
    .fw_count(fw_count), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .buf_data(buf_data), .buf_valid(buf_valid),
    .buf_ready(buf_ready), .resp_valid_r(resp_valid_r),
    .resp_code_r(resp_code_r), .resp_ep_r(resp_ep_r),
    .resp_len_r(resp_len_r), .resp_tog_r(resp_tog_r),
    .ep_mode(ep_mode), .ep_dtog(ep_dtog), .ep_dval(ep_dval),
    .ep_rxcnt(ep_rxcnt), .ep_int(ep_int));

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task fwr(input [1:0] ep, input [3:0] m, input st, input [3:0] cnt);
    @(posedge clk);
    fw_we <= 1'b1;
    fw_ep <= ep;
    fw_mode <= m;
    fw_stall[ep] <= st;
    fw_count[ep*4 +: 4] <= cnt;
    @(posedge clk);
    fw_we <= 1'b0;
  endtask

  // Program mode, send one token, check the answer a cycle later
  task tok(input [1:0] ep, input [3:0] m, input st, input [1:0] pid,
           input [4:0] len, input ok, input tog, input [3:0] cnt,
           input ev, input [2:0] ec, input [3:0] em);
    logic [3:0] el;
    el = (m == 4'hF || m == 4'hD) ? cnt : 4'h0;
    fwr(ep, m, st, cnt);
    u_host.token(pid, ep, len, ok, tog);
    #1;
    chk("resp_valid", ev, resp_valid_r);
    if (ev) begin
      chk("resp_code", ec, resp_code_r);
      chk("resp_ep", ep, resp_ep_r);
      if (ec == DT) chk("resp_len", el, resp_len_r);
      chk("resp_tog", cnt[3], resp_tog_r);
    end
    chk("ep_mode", em, mode_all[ep*4 +: 4]);
    chk("ep_int", ev && (ec == AK || em != m), int_all[ep]);
  endtask

  task acks(input [1:0] ep, input a, input [3:0] em);
    u_host.give_ack(a);
    #1;
    chk("ack_mode", em, ep_mode[ep*4 +: 4]);
    chk("ack_int", a, ep_int[ep]);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    finish_test;
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk("rst_mode", 12'h000, ep_mode);
    chk("rst_ready", 0, rx_ready);
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("rx_ready", 1, rx_ready);
    // ----------------------------------------
    // Control endpoint modes
    // ----------------------------------------
    tok(0, 4'h0, 0, SU, 10, 1, 0, 0, 0, AK, 4'h0);
    tok(1, 4'h0, 0, OU, 2, 1, 1, 0, 0, AK, 4'h0);
    tok(0, 4'h1, 0, IN, 2, 1, 0, 0, 1, NK, 4'h1);
    tok(0, 4'h1, 0, OU, 4, 1, 0, 0, 1, NK, 4'h1);
    tok(0, 4'h2, 0, IN, 2, 1, 0, 0, 1, SL, 4'h3);
    tok(0, 4'h2, 0, OU, 2, 1, 1, 0, 1, AK, 4'h2);
    chk("dtog", 1, ep_dtog[0]);
    tok(0, 4'h2, 0, OU, 2, 1, 0, 0, 1, SL, 4'h3);
    tok(0, 4'h2, 0, OU, 5, 1, 1, 0, 1, SL, 4'h3);
    tok(0, 4'h3, 0, IN, 2, 1, 0, 0, 1, SL, 4'h3);
    tok(0, 4'h3, 0, OU, 6, 1, 0, 0, 1, SL, 4'h3);
    tok(0, 4'h3, 0, SU, 10, 1, 0, 0, 1, AK, 4'h1);
    chk("dval", 1, ep_dval[0]);
    chk("rxcnt", 10, ep_rxcnt[4:0]);
    tok(0, 4'h3, 0, SU, 11, 1, 0, 0, 0, AK, 4'h3);
    tok(0, 4'h3, 0, OU, 4, 0, 0, 0, 0, AK, 4'h3);
    tok(3, 4'h1, 0, IN, 2, 1, 0, 0, 0, AK, 4'h0);
    tok(0, 4'h6, 0, OU, 2, 1, 1, 0, 1, SL, 4'h3);
    tok(0, 4'h6, 0, IN, 2, 1, 0, 0, 1, DT, 4'h6);
    acks(0, 1, 4'h3);
    tok(0, 4'hB, 0, OU, 8, 1, 0, 0, 1, AK, 4'h1);
    tok(0, 4'hB, 0, IN, 2, 1, 0, 0, 1, DT, 4'hB);
    acks(0, 1, 4'h3);
    tok(0, 4'hF, 0, OU, 2, 1, 1, 0, 1, AK, 4'h2);
    tok(0, 4'hF, 0, IN, 2, 1, 0, 4'hF, 1, DT, 4'hF);
    acks(0, 1, 4'h1);
    $display("control endpoint test done");
    // ----------------------------------------
    // Data endpoint modes, then reserved modes on endpoint 0
    // ----------------------------------------
    tok(1, 4'h8, 0, OU, 3, 1, 0, 0, 1, NK, 4'h8);
    tok(1, 4'h8, 0, IN, 2, 1, 0, 0, 0, AK, 4'h8);
    tok(2, 4'h8, 0, SU, 10, 1, 0, 0, 0, AK, 4'h8);
    tok(2, 4'h9, 0, OU, 10, 1, 0, 0, 1, AK, 4'h8);
    tok(2, 4'h9, 0, OU, 12, 1, 0, 0, 0, AK, 4'h9);
    tok(1, 4'h9, 1, OU, 4, 1, 0, 0, 1, SL, 4'h9);
    tok(1, 4'h9, 1, IN, 2, 1, 0, 0, 0, AK, 4'h9);
    tok(2, 4'hC, 0, IN, 2, 1, 0, 0, 1, NK, 4'hC);
    tok(2, 4'hC, 0, OU, 2, 1, 0, 0, 0, AK, 4'hC);
    tok(1, 4'hD, 0, IN, 2, 1, 0, 4'h5, 1, DT, 4'hD);
    acks(1, 0, 4'hD);
    tok(2, 4'hD, 0, IN, 2, 1, 0, 4'h8, 1, DT, 4'hD);
    acks(2, 1, 4'hC);
    tok(1, 4'hD, 1, IN, 2, 1, 0, 4'h5, 1, SL, 4'hD);
    tok(1, 4'hD, 1, SU, 10, 1, 0, 4'h5, 0, AK, 4'hD);
    for (k = 0; k < 15; k++)
      tok(0, rsv[k/3], 0, k % 3, 2, 1, 1, 0, 0, AK, rsv[k/3]);
    $display("data endpoint test done");
    // ----------------------------------------
    // Engine write beats firmware write
    // ----------------------------------------
    fwr(2, 4'hC, 0, 0);
    fwr(1, 4'h9, 0, 0);
    @(posedge clk);
    fw_we <= 1'b1;
    fw_ep <= 2'h2;
    fw_mode <= 4'h1;
    u_host.token(OU, 1, 2, 1, 0);
    fw_we <= 1'b0;
    #1;
    chk("engine_mode", 4'h8, ep_mode[7:4]);
    chk("fw_dropped", 4'hC, ep_mode[11:8]);
    fwr(2, 4'h1, 0, 0);
    #1;
    chk("fw_rewrite", 4'h1, ep_mode[11:8]);
    $display("write priority test done");
    // ----------------------------------------
    // Receive FIFO fill and drain
    // ----------------------------------------
    n = 0;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= 8'h00;
    repeat (40) begin
      @(negedge clk);
      rdy = rx_ready;
      @(posedge clk);
      if (rdy) begin
        n++;
        rx_data <= n[7:0];
      end
    end
    rx_valid <= 1'b0;
    #1;
    chk("fill_count", 1, n >= 31 && n <= 32);
    chk("full_ready", 0, rx_ready);
    k = 0;
    repeat (100) begin
      @(negedge clk);
      if (buf_valid && buf_ready) begin
        chk("buf_data", k[7:0], buf_data);
        k++;
      end
      @(posedge clk);
      buf_ready <= ~buf_ready;
    end
    #1;
    chk("drained", n, k);
    chk("empty", 0, buf_valid);
    $display("fifo test done");
    finish_test;
  end
endmodule
